// *** src/scbc_device.sv ***
// device end: serial target and control register bank
//
// Notes on behaviour
// - acknowledge write address after start
// - acknowledge and latch starting index
// - acknowledge read address after repeated start
// - first read byte is readback count
// - then registers N through N+X-1
// - host acknowledges all but last byte
// - host nack then stop; release data
// - write: index, count, data bytes, stop
// - acknowledge every write byte
// - reg0 bit7 source, bit1 bandwidth
// - reg0 bit0 clear bypasses pll
// - reg1 bits 5,3,2,0 enable outputs
// - reg5 readback count, resets to six
// - reg3 revision/maker, reg4 part id
// - reg2 reserved storage only
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module scbc_device
(
  // system
  input  wire logic clk,
  input  wire logic resetn,
  // link
  scbc_link_if.dev  link,
  // control outputs
  output logic      pllCtrlSourceSel,
  output logic      pllBandwidthSel,
  output logic      pllEnable,
  output logic [3:0] outPairEn,
  output logic      busy
);
  import scbc_pkg::*;

  typedef enum logic [2:0] {
    SCBC_IDLE   = 3'b000,
    SCBC_RXBYTE = 3'b001,
    SCBC_ACK    = 3'b011,
    SCBC_TXBYTE = 3'b010,
    SCBC_TXACK  = 3'b110,
    SCBC_IGNORE = 3'b111
  } scbc_state_type;

  ////////////////////////////////////////////////////////////////////////
  // input synchronisers and edge detection
  logic [1:0] sclkSync_r;
  logic [1:0] sdatSync_r;
  logic       sclkPrev_r;
  logic       sdatPrev_r;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sclkSync_r <= 2'h3;
      sdatSync_r <= 2'h3;
      sclkPrev_r <= 1'b1;
      sdatPrev_r <= 1'b1;
    end
    else
    begin
      sclkSync_r <= {sclkSync_r[0], link.sclk};
      sdatSync_r <= {sdatSync_r[0], link.sdat};
      sclkPrev_r <= sclkSync_r[1];
      sdatPrev_r <= sdatSync_r[1];
    end
  end
  wire sclkS  = sclkSync_r[1];
  wire sdatS  = sdatSync_r[1];
  wire sclkRise = sclkS & ~sclkPrev_r;
  wire sclkFall = ~sclkS & sclkPrev_r;
  wire startCond = sclkS & sclkPrev_r & sdatPrev_r & ~sdatS;
  wire stopCond  = sclkS & sclkPrev_r & ~sdatPrev_r & sdatS;

  ////////////////////////////////////////////////////////////////////////
  // protocol engine
  scbc_state_type state_r;
  logic [7:0] shift_r;
  logic [3:0] bitCnt_r;
  logic [2:0] byteNo_r;   // 0 addr, 1 index, 2 count, 3 data
  logic       readDir_r;
  logic [7:0] index_r;
  logic       ackDrive_r;
  logic       txDrive_r;
  logic       wrStb;
  logic [7:0] regFile_r [SCBC_NUM_REGS];

  function automatic logic [7:0] rdReg(input logic [7:0] idx);
    case (idx)
      SCBC_REG_REVVEND: rdReg = {SCBC_REV_ID, SCBC_MAKER_ID};
      SCBC_REG_PARTID:  rdReg = SCBC_PART_ID;
      default:          rdReg = (idx < 8'(SCBC_NUM_REGS)) ? regFile_r[idx[2:0]] : 8'h00;
    endcase
  endfunction

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r     <= SCBC_IDLE;
      shift_r     <= 8'h00;
      bitCnt_r    <= 4'h0;
      byteNo_r    <= 3'h0;
      readDir_r   <= 1'b0;
      index_r     <= 8'h00;
      ackDrive_r  <= 1'b0;
      txDrive_r   <= 1'b0;
    end
    else if (stopCond)
    begin
      state_r    <= SCBC_IDLE;
      ackDrive_r <= 1'b0;
      txDrive_r  <= 1'b0;
    end
    else if (startCond)
    begin
      state_r    <= SCBC_RXBYTE;
      bitCnt_r   <= 4'h0;
      byteNo_r   <= 3'h0;
      ackDrive_r <= 1'b0;
      txDrive_r  <= 1'b0;
    end
    else
    begin
      case (state_r)
        SCBC_RXBYTE:
        begin
          if (sclkRise)
          begin
            shift_r  <= {shift_r[6:0], sdatS};
            bitCnt_r <= bitCnt_r + 4'h1;
          end
          else if (sclkFall && bitCnt_r == 4'h8)
          begin
            bitCnt_r <= 4'h0;
            if (byteNo_r == 3'h0)
            begin
              if (shift_r[7:1] == SCBC_TARGET_ADDR)
              begin
                readDir_r  <= shift_r[0];
                ackDrive_r <= 1'b1;
                state_r    <= SCBC_ACK;
              end
              else
                state_r <= SCBC_IGNORE;
            end
            else
            begin
              if (byteNo_r == 3'h1)
                index_r <= shift_r;
              ackDrive_r <= 1'b1;
              state_r    <= SCBC_ACK;
            end
          end
        end
        SCBC_ACK:
        begin
          if (sclkFall)
          begin
            ackDrive_r <= 1'b0;
            if (byteNo_r == 3'h3)
              index_r <= index_r + 8'h01;
            if (byteNo_r != 3'h3)
              byteNo_r <= byteNo_r + 3'h1;
            if (byteNo_r == 3'h0 && readDir_r)
            begin
              shift_r     <= regFile_r[SCBC_REG_RBLEN[2:0]];
              txDrive_r   <= ~regFile_r[SCBC_REG_RBLEN[2:0]][7];
              bitCnt_r    <= 4'h1;
              state_r     <= SCBC_TXBYTE;
            end
            else
              state_r <= SCBC_RXBYTE;
          end
        end
        SCBC_TXBYTE:
        begin
          if (sclkFall)
          begin
            if (bitCnt_r == 4'h8)
            begin
              txDrive_r <= 1'b0;                                // release for host ack
              state_r   <= SCBC_TXACK;
            end
            else
            begin
              shift_r   <= {shift_r[6:0], 1'b0};
              txDrive_r <= ~shift_r[6];
              bitCnt_r  <= bitCnt_r + 4'h1;
            end
          end
        end
        SCBC_TXACK:
        begin
          if (sclkRise)
          begin
            if (sdatS)
              state_r <= SCBC_IGNORE;
            else
            begin
              // index steps as each byte is loaded, so register N goes out first
              shift_r     <= rdReg(index_r);
              index_r     <= index_r + 8'h01;
              bitCnt_r    <= 4'h0;
            end
          end
          else if (sclkFall && !sdatS)
          begin
            txDrive_r <= ~shift_r[7];
            bitCnt_r  <= 4'h1;
            state_r   <= SCBC_TXBYTE;
          end
        end
        SCBC_IGNORE: ;
        default: state_r <= SCBC_IDLE;
      endcase
    end
  end

  // a data byte lands on the falling edge that opens its ack slot
  assign wrStb = (state_r == SCBC_RXBYTE) && !stopCond && !startCond && sclkFall
                 && bitCnt_r == 4'h8 && byteNo_r == 3'h3;

  ////////////////////////////////////////////////////////////////////////
  // register bank
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      regFile_r[0] <= SCBC_PLLCTL_RST;
      regFile_r[1] <= SCBC_OUTEN_RST;
      regFile_r[2] <= SCBC_SPARE_RST;
      regFile_r[3] <= 8'h00;
      regFile_r[4] <= 8'h00;
      regFile_r[5] <= SCBC_RBLEN_RST;
    end
    else if (wrStb && index_r < 8'(SCBC_NUM_REGS)
             && index_r != SCBC_REG_REVVEND && index_r != SCBC_REG_PARTID)
      regFile_r[index_r[2:0]] <= shift_r;
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign pllCtrlSourceSel = regFile_r[0][SCBC_BIT_SRCSEL];
  assign pllBandwidthSel  = regFile_r[0][SCBC_BIT_BWSEL];
  assign pllEnable        = regFile_r[0][SCBC_BIT_PLLEN];
  assign outPairEn        = {regFile_r[1][5], regFile_r[1][3], regFile_r[1][2], regFile_r[1][0]};
  assign busy             = (state_r != SCBC_IDLE);
  // open drain: enable low means pulling low
  assign link.sdatDevOut  = 1'b0;
  assign link.sdatDevOen  = ~(ackDrive_r | txDrive_r);
endmodule
`default_nettype wire

// *** src/scbc_host.sv ***
// host end: block write and indexed read master with a register port
`timescale 1ns/10ps
`default_nettype none
module scbc_host
(
  // system
  input  wire logic       clk,
  input  wire logic       resetn,
  // register port
  input  wire logic [3:0] regAddr,
  input  wire logic [7:0] regWdata,
  input  wire logic       regWr,
  input  wire logic       regRd,
  output logic      [7:0] regRdata,
  // link
  scbc_link_if.host       link
);
  import scbc_pkg::*;

  typedef enum logic [2:0] {
    SCBC_H_IDLE  = 3'b000,
    SCBC_H_START = 3'b001,
    SCBC_H_BITS  = 3'b011,
    SCBC_H_RSTRT = 3'b010,
    SCBC_H_STOP  = 3'b110
  } scbc_hstate_type;

  ////////////////////////////////////////////////////////////////////////
  // registers: ctrl {go,cmd}, index, count, data buffer
  logic [7:0] index_r;
  logic [7:0] count_r;
  logic [1:0] cmd_r;
  logic       nackSeen_r;
  logic [7:0] buf_r [8];
  logic       goPulse;
  scbc_hstate_type state_r;
  logic [1:0] sdatSync_r;
  assign goPulse = regWr && regAddr == SCBC_H_CTRL && state_r == SCBC_H_IDLE;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      index_r <= 8'h00;
      count_r <= 8'h00;
      cmd_r   <= 2'h0;
    end
    else if (goPulse)
      cmd_r <= regWdata[1:0];
    else if (regWr && regAddr == 4'h2)
      index_r <= regWdata;
    else if (regWr && regAddr == 4'h3)
      count_r <= regWdata;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      regRdata <= 8'h00;
    else if (regRd)
      case (regAddr)
        SCBC_H_STAT: regRdata <= {6'h00, nackSeen_r, state_r != SCBC_H_IDLE};
        4'h2:        regRdata <= index_r;
        4'h3:        regRdata <= count_r;
        default:     regRdata <= regAddr[3] ? buf_r[regAddr[2:0]] : 8'h00;
      endcase
    else
      regRdata <= 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////
  // bit engine: each bit cell is four quarters of SCBC_HALF_CYC/2 clocks
  logic [7:0] tick_r;
  logic [1:0] phase_r;
  logic [3:0] bitCnt_r;
  logic [4:0] byteNo_r;
  logic [7:0] sh_r;
  logic       sclkLow_r;
  logic       sdatLow_r;
  logic       rdPhase_r;
  wire        qEnd = (tick_r == 8'(SCBC_HALF_CYC / 2 - 1));
  wire        sdatS = sdatSync_r[1];

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      sdatSync_r <= 2'h3;
    else
      sdatSync_r <= {sdatSync_r[0], link.sdat};
  end

  // next byte to shift during the write-direction phases
  function automatic logic [7:0] txByte(input logic [4:0] n);
    case (n)
      5'h00:   txByte = {SCBC_TARGET_ADDR, 1'b0};
      5'h01:   txByte = index_r;
      5'h02:   txByte = count_r;
      default: txByte = buf_r[3'(n - 5'h03)];
    endcase
  endfunction

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r    <= SCBC_H_IDLE;
      tick_r     <= 8'h00;
      phase_r    <= 2'h0;
      bitCnt_r   <= 4'h0;
      byteNo_r   <= 5'h00;
      sh_r       <= 8'h00;
      sclkLow_r  <= 1'b0;
      sdatLow_r  <= 1'b0;
      rdPhase_r  <= 1'b0;
      nackSeen_r <= 1'b0;
      for (int i = 0; i < 8; i++)
        buf_r[i] <= 8'h00;
    end
    else
    begin
      if (regWr && regAddr[3] && state_r == SCBC_H_IDLE)
        buf_r[regAddr[2:0]] <= regWdata;
      tick_r <= qEnd ? 8'h00 : tick_r + 8'h01;
      if (goPulse && (regWdata[1:0] == SCBC_CMD_WRITE || regWdata[1:0] == SCBC_CMD_READ))
      begin
        state_r    <= SCBC_H_START;
        phase_r    <= 2'h0;
        tick_r     <= 8'h00;
        nackSeen_r <= 1'b0;
        rdPhase_r  <= 1'b0;
        byteNo_r   <= 5'h00;
      end
      else if (qEnd && state_r != SCBC_H_IDLE)
      begin
        phase_r <= phase_r + 2'h1;
        case (state_r)
          SCBC_H_START, SCBC_H_RSTRT:
            // q0 release data, q1 clock high, q2 data low, q3 clock low
            // clock stays low until the target has let go of its ack, else a stop is seen
            case (phase_r)
              2'h0: sdatLow_r <= 1'b0;
              2'h1: sclkLow_r <= 1'b0;
              2'h2: sdatLow_r <= 1'b1;
              default:
              begin
                sclkLow_r <= 1'b1;
                sh_r     <= rdPhase_r ? {SCBC_TARGET_ADDR, 1'b1} : txByte(byteNo_r);
                bitCnt_r <= 4'h0;
                state_r  <= SCBC_H_BITS;
              end
            endcase
          SCBC_H_BITS:
            case (phase_r)
              2'h0:
              begin
                // present a bit: write bits, our ack of a read byte, or release
                if (bitCnt_r == 4'h8)
                  sdatLow_r <= rdPhase_r && byteNo_r != 5'h00
                               && byteNo_r <= 5'(count_r);      // ack all but last
                else
                  sdatLow_r <= (rdPhase_r && byteNo_r != 5'h00) ? 1'b0 : ~sh_r[7];
              end
              2'h1: sclkLow_r <= 1'b0;
              2'h2:
              begin
                if (bitCnt_r == 4'h8)
                begin
                  if (!(rdPhase_r && byteNo_r != 5'h00) && sdatS)
                    nackSeen_r <= 1'b1;
                  if (rdPhase_r && byteNo_r > 5'h01)
                    buf_r[3'(byteNo_r - 5'h02)] <= sh_r;
                end
                else
                  sh_r <= {sh_r[6:0], sdatS};
              end
              default:
              begin
                sclkLow_r <= 1'b1;
                if (bitCnt_r != 4'h8)
                  bitCnt_r <= bitCnt_r + 4'h1;
                else
                begin
                  bitCnt_r <= 4'h0;
                  byteNo_r <= byteNo_r + 5'h01;
                  if (nackSeen_r)
                    state_r <= SCBC_H_STOP;
                  else if (!rdPhase_r && cmd_r == SCBC_CMD_READ && byteNo_r == 5'h01)
                  begin
                    rdPhase_r <= 1'b1;
                    byteNo_r  <= 5'h00;
                    state_r   <= SCBC_H_RSTRT;
                  end
                  else if (!rdPhase_r && cmd_r == SCBC_CMD_WRITE
                           && byteNo_r == 5'(count_r) + 5'h02)
                    state_r <= SCBC_H_STOP;
                  else if (rdPhase_r && byteNo_r == 5'(count_r) + 5'h01)
                    state_r <= SCBC_H_STOP;
                  else if (!rdPhase_r)
                    sh_r <= txByte(byteNo_r + 5'h01);
                  else
                    sh_r <= 8'h00;
                end
              end
            endcase
          SCBC_H_STOP:
            // data low, clock high, data high
            case (phase_r)
              2'h0: sdatLow_r <= 1'b1;
              2'h1: sclkLow_r <= 1'b0;
              2'h2: sdatLow_r <= 1'b0;
              default: state_r <= SCBC_H_IDLE;
            endcase
          default: state_r <= SCBC_H_IDLE;
        endcase
      end
    end
  end

  assign link.sclkOut     = 1'b0;
  assign link.sclkOen     = ~sclkLow_r;
  assign link.sdatHostOut = 1'b0;
  assign link.sdatHostOen = ~sdatLow_r;
endmodule
`default_nettype wire

// *** src/scbc_link_if.sv ***
// open-drain management link between host and device
`timescale 1ns/10ps
`default_nettype none
interface scbc_link_if;
  logic sclkOut;
  logic sclkOen;
  logic sdatHostOut;
  logic sdatHostOen;
  logic sdatDevOut;
  logic sdatDevOen;
  // wired-and of the open-drain drivers, pulled high
  wire  sclk = sclkOen | sclkOut;
  wire  sdat = (sdatHostOen | sdatHostOut) & (sdatDevOen | sdatDevOut);
  modport host (output sclkOut, output sclkOen, output sdatHostOut, output sdatHostOen,
                input sclk, input sdat);
  modport dev  (output sdatDevOut, output sdatDevOen, input sclk, input sdat);
endinterface
`default_nettype wire

// *** src/scbc_pkg.sv ***
// shared constants for the clock buffer management link
package scbc_pkg;
  localparam logic [6:0] SCBC_TARGET_ADDR   = 7'h6a;
  localparam logic [7:0] SCBC_REG_PLLCTL    = 8'h00;
  localparam logic [7:0] SCBC_REG_OUTEN     = 8'h01;
  localparam logic [7:0] SCBC_REG_SPARE     = 8'h02;
  localparam logic [7:0] SCBC_REG_REVVEND   = 8'h03;
  localparam logic [7:0] SCBC_REG_PARTID    = 8'h04;
  localparam logic [7:0] SCBC_REG_RBLEN     = 8'h05;
  localparam int         SCBC_NUM_REGS      = 6;
  localparam int         SCBC_BIT_SRCSEL    = 7;
  localparam int         SCBC_BIT_BWSEL     = 1;
  localparam int         SCBC_BIT_PLLEN     = 0;
  localparam logic [7:0] SCBC_PLLCTL_RST    = 8'h83;
  localparam logic [7:0] SCBC_OUTEN_RST     = 8'h2d;
  localparam logic [7:0] SCBC_OUTEN_MASK    = 8'h2d;
  localparam logic [7:0] SCBC_RBLEN_RST     = 8'h06;
  localparam logic [7:0] SCBC_SPARE_RST     = 8'h00;
  // identity values are arbitrary
  localparam logic [3:0] SCBC_REV_ID        = 4'h3;
  localparam logic [3:0] SCBC_MAKER_ID      = 4'h5;
  localparam logic [7:0] SCBC_PART_ID       = 8'h5a;
  // host bit cell: link clock half period in system clocks (25 MHz / 4 per half = 160 ns)
  localparam int         SCBC_HALF_CYC      = 4;
  // host command codes
  localparam logic [1:0] SCBC_CMD_WRITE     = 2'h1;
  localparam logic [1:0] SCBC_CMD_READ      = 2'h2;
  // host register map
  localparam logic [3:0] SCBC_H_CTRL        = 4'h0;
  localparam logic [3:0] SCBC_H_STAT        = 4'h1;
  localparam logic [3:0] SCBC_H_DATA0       = 4'h8;
endpackage

// *** tb/scbc_link_checker.sv ***
// concurrent checks on the management link between host and device
`timescale 1ns/10ps
`default_nettype none
module scbc_link_checker
(
  // system
  input  wire logic clk,
  input  wire logic resetn,
  // link drivers and resolved lines
  input  wire logic sclkOen,
  input  wire logic sdatHostOen,
  input  wire logic sdatDevOen,
  input  wire logic sclk,
  input  wire logic sdat
);
  import scbc_pkg::*;
  ////////////////////////////////////////////////////////////////////////////
  logic       sclkQ_r;
  logic       sdatQ_r;
  logic       inFrame_r;
  logic       addrOk_r;
  logic       rdDir_r;
  logic [3:0] bitCnt_r;
  logic [3:0] byteCnt_r;
  logic [7:0] shift_r;
  logic       startSeen;
  logic       stopSeen;
  logic       riseSeen;
  logic       ackSlot;
  logic       dataSlot;
  assign startSeen = sclk & sclkQ_r & sdatQ_r & ~sdat;
  assign stopSeen  = sclk & sclkQ_r & ~sdatQ_r & sdat;
  assign riseSeen  = sclk & ~sclkQ_r & inFrame_r;
  assign ackSlot   = riseSeen & (bitCnt_r == 4'h8);
  assign dataSlot  = riseSeen & (bitCnt_r != 4'h8);
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sclkQ_r <= 1'b1;
      sdatQ_r <= 1'b1;
    end
    else
    begin
      sclkQ_r <= sclk;
      sdatQ_r <= sdat;
    end
  end
  // a repeated start shifts in one stray bit first; the start clears it again
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      inFrame_r <= 1'b0;
      addrOk_r  <= 1'b0;
      rdDir_r   <= 1'b0;
      bitCnt_r  <= 4'h0;
      byteCnt_r <= 4'h0;
      shift_r   <= 8'h00;
    end
    else if (startSeen)
    begin
      inFrame_r <= 1'b1;
      bitCnt_r  <= 4'h0;
      byteCnt_r <= 4'h0;
    end
    else if (stopSeen)
    begin
      inFrame_r <= 1'b0;
      addrOk_r  <= 1'b0;
    end
    else if (dataSlot)
    begin
      shift_r  <= {shift_r[6:0], sdat};
      bitCnt_r <= bitCnt_r + 4'h1;
    end
    else if (ackSlot)
    begin
      bitCnt_r <= 4'h0;
      if (byteCnt_r != 4'hf)
        byteCnt_r <= byteCnt_r + 4'h1;
      if (byteCnt_r == 4'h0)
      begin
        addrOk_r <= (shift_r[7:1] == SCBC_TARGET_ADDR);
        rdDir_r  <= shift_r[0];
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_ack_wr_addr;
    ackSlot && byteCnt_r == 4'h0 && shift_r == {SCBC_TARGET_ADDR, 1'b0} |-> !sdatDevOen;
  endproperty
  a_ack_wr_addr: assert property (p_ack_wr_addr) else $error("write address not acknowledged");
  property p_ack_rd_addr;
    ackSlot && byteCnt_r == 4'h0 && shift_r == {SCBC_TARGET_ADDR, 1'b1} |-> !sdatDevOen;
  endproperty
  a_ack_rd_addr: assert property (p_ack_rd_addr) else $error("read address not acknowledged");
  property p_ack_wr_bytes;
    ackSlot && byteCnt_r != 4'h0 && addrOk_r && !rdDir_r |-> !sdatDevOen;
  endproperty
  a_ack_wr_bytes: assert property (p_ack_wr_bytes) else $error("written byte not acknowledged");
  property p_rd_ack_free;
    ackSlot && byteCnt_r != 4'h0 && addrOk_r && rdDir_r |-> sdatDevOen;
  endproperty
  a_rd_ack_free: assert property (p_rd_ack_free) else $error("device holds line in host ack slot");
  // the msb slot is skipped: the stop condition starts there with the host low
  property p_rd_host_free;
    dataSlot && bitCnt_r != 4'h0 && byteCnt_r != 4'h0 && addrOk_r && rdDir_r |-> sdatHostOen;
  endproperty
  a_rd_host_free: assert property (p_rd_host_free) else $error("host drives line during read data");
  property p_idle_free;
    !inFrame_r |-> sdatDevOen;
  endproperty
  a_idle_free: assert property (p_idle_free) else $error("device drives line outside a frame");
  property p_dev_hold;
    sclk && sclkQ_r |-> $stable(sdatDevOen);
  endproperty
  a_dev_hold: assert property (p_dev_hold) else $error("device data moved while clock high");
  property p_sclk_high;
    $rose(sclk) |-> sclk [*3];
  endproperty
  a_sclk_high: assert property (p_sclk_high) else $error("link clock high phase too short");
  property p_sclk_low;
    $fell(sclk) |-> !sclk [*3];
  endproperty
  a_sclk_low: assert property (p_sclk_low) else $error("link clock low phase too short");
endmodule
`default_nettype wire

// *** tb/smbus_clock_buffer_ctrl_tb.sv ***
// self-checking bench: host and device joined, plus a bench-driven second link
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, gt) begin samplesChecked++; if ((gt) !== (ex)) begin nErrors++; $display("BAD %s exp %h got %h", nm, ex, gt); end end
module smbus_clock_buffer_ctrl_tb;
  import scbc_pkg::*;
  ////////////////////////////////////////////////////////////////////////////
  logic       clk;
  logic       resetn;
  logic [3:0] regAddr;
  logic [7:0] regWdata;
  logic       regWr;
  logic       regRd;
  logic [7:0] regRdata;
  logic       srcSel;
  logic       bwSel;
  logic       pllEn;
  logic [3:0] outEn;
  logic       busy;
  logic       busyB;
  logic [7:0] pat [6];
  logic [7:0] r;
  logic       a;
  int         nErrors = 0;
  int         samplesChecked = 0;
  int         cycles = 0;
  scbc_link_if linkA();
  scbc_link_if linkB();
  scbc_host scbc_host_inst (.clk(clk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .link(linkA));
  scbc_device scbc_device_inst (.clk(clk), .resetn(resetn), .link(linkA), .pllCtrlSourceSel(srcSel),
    .pllBandwidthSel(bwSel), .pllEnable(pllEn), .outPairEn(outEn), .busy(busy));
  // second device faces bench-driven lines so host faults can be staged
  scbc_device scbc_device_b_inst (.clk(clk), .resetn(resetn), .link(linkB), .pllCtrlSourceSel(),
    .pllBandwidthSel(), .pllEnable(), .outPairEn(), .busy(busyB));
  scbc_link_checker scbc_link_checker_inst (.clk(clk), .resetn(resetn), .sclkOen(linkA.sclkOen),
    .sdatHostOen(linkA.sdatHostOen), .sdatDevOen(linkA.sdatDevOen), .sclk(linkA.sclk), .sdat(linkA.sdat));
  ////////////////////////////////////////////////////////////////////////////
  task automatic closeOut();
    if (nErrors == 0 && samplesChecked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic regWrite(input logic [3:0] ad, input logic [7:0] d);
    @(posedge clk);
    regAddr  <= ad;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge clk);
    regWr    <= 1'b0;
  endtask
  task automatic regRead(input logic [3:0] ad, output logic [7:0] d);
    @(posedge clk);
    regAddr <= ad;
    regRd   <= 1'b1;
    @(posedge clk);
    regRd   <= 1'b0;
    #1 d = regRdata;
  endtask
  task automatic runCmd(input logic [1:0] cmd, input logic [7:0] idx, input logic [7:0] cnt);
    logic [7:0] s;
    int         i;
    regWrite(4'h2, idx);
    regWrite(4'h3, cnt);
    regWrite(SCBC_H_CTRL, {6'h00, cmd});
    s = 8'h01;
    i = 0;
    // bounded poll: a hung transfer ends here on the host busy check, long before the timeout
    while (s[0] !== 1'b0 && i < 3000)
    begin
      regRead(SCBC_H_STAT, s);
      i++;
    end
    `CHK("host busy", 1'b0, s[0])
    `CHK("nack flag", 1'b0, s[1])
    `CHK("device busy", 1'b0, busy)
  endtask
  task automatic blockWrite(input logic [7:0] idx, input int n);
    for (int i = 0; i < n; i++)
      regWrite(SCBC_H_DATA0 + 4'(i), pat[i]);
    runCmd(SCBC_CMD_WRITE, idx, 8'(n));
  endtask
  task automatic blockRead(input logic [7:0] idx, input int n);
    logic [7:0] d;
    runCmd(SCBC_CMD_READ, idx, 8'(n));
    for (int i = 0; i < n; i++)
    begin
      regRead(SCBC_H_DATA0 + 4'(i), d);
      `CHK("read byte", pat[i], d)
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // bit cell on the second link: four quarters of two clocks each
  task automatic bbBit(input logic b, output logic s);
    linkB.sdatHostOen <= b;
    repeat (2) @(posedge clk);
    linkB.sclkOen <= 1'b1;
    repeat (2) @(posedge clk);
    s = linkB.sdat;
    repeat (2) @(posedge clk);
    linkB.sclkOen <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic bbByte(input logic [7:0] d, input logic ackIn, output logic [7:0] rd, output logic ackOut);
    logic t;
    for (int i = 7; i >= 0; i--)
    begin
      bbBit(d[i], t);
      rd[i] = t;
    end
    bbBit(ackIn, ackOut);
  endtask
  task automatic bbStart();
    linkB.sdatHostOen <= 1'b1;
    repeat (2) @(posedge clk);
    linkB.sclkOen <= 1'b1;
    repeat (2) @(posedge clk);
    linkB.sdatHostOen <= 1'b0;
    repeat (2) @(posedge clk);
    linkB.sclkOen <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic bbStop();
    linkB.sdatHostOen <= 1'b0;
    repeat (2) @(posedge clk);
    linkB.sclkOen <= 1'b1;
    repeat (2) @(posedge clk);
    linkB.sdatHostOen <= 1'b1;
    repeat (2) @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      nErrors++;
      closeOut();
    end
  end
  initial
  begin
    resetn = 1'b0;
    regAddr = 4'h0;
    regWdata = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
    linkB.sclkOut = 1'b0;
    linkB.sclkOen = 1'b1;
    linkB.sdatHostOut = 1'b0;
    linkB.sdatHostOen = 1'b1;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    pat = '{8'h83, 8'h2d, 8'h00, {SCBC_REV_ID, SCBC_MAKER_ID}, SCBC_PART_ID, 8'h06};
    blockRead(8'h00, 6);
    `CHK("controls at reset", 7'h7f, {srcSel, bwSel, pllEn, outEn})
    // reserved bits set, identity bytes written but kept, count cut to three
    pat = '{8'h7e, 8'hf6, 8'ha5, 8'hff, 8'h00, 8'h03};
    blockWrite(8'h00, 6);
    `CHK("controls after write", 7'h2a, {srcSel, bwSel, pllEn, outEn})
    pat = '{{SCBC_REV_ID, SCBC_MAKER_ID}, SCBC_PART_ID, 8'h03, 8'h00, 8'h00, 8'h00};
    blockRead(8'h03, 3);
    pat = '{8'h7e, 8'hf6, 8'ha5, 8'h00, 8'h00, 8'h00};
    blockRead(8'h00, 3);
    pat[0] = 8'h81;
    blockWrite(8'h00, 1);
    `CHK("low bandwidth", 7'h5a, {srcSel, bwSel, pllEn, outEn})
    pat[0] = 8'h02;
    blockWrite(8'h05, 1);
    pat = '{SCBC_PART_ID, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00};
    blockRead(8'h04, 2);
    // an unknown command code must not start a transfer
    regWrite(SCBC_H_CTRL, 8'h03);
    regRead(SCBC_H_STAT, r);
    `CHK("unknown command", 8'h00, r)
    // second link: foreign address, then a read cut short after the count
    @(posedge clk);
    bbStart();
    bbByte(8'ha0, 1'b1, r, a);
    `CHK("foreign address ack", 1'b1, a)
    bbStop();
    bbStart();
    bbByte({SCBC_TARGET_ADDR, 1'b0}, 1'b1, r, a);
    `CHK("write address ack", 1'b0, a)
    bbByte(8'h00, 1'b1, r, a);
    `CHK("index ack", 1'b0, a)
    bbStart();
    bbByte({SCBC_TARGET_ADDR, 1'b1}, 1'b1, r, a);
    `CHK("read address ack", 1'b0, a)
    bbByte(8'hff, 1'b1, r, a);
    `CHK("count byte", SCBC_RBLEN_RST, r)
    bbStop();
    repeat (4) @(posedge clk);
    #1;
    `CHK("line released", 1'b1, linkB.sdat)
    `CHK("busy after stop", 1'b0, busyB)
    closeOut();
  end
endmodule
`undef CHK
`default_nettype wire
